// File: core/mtl_pkg.sv
// shared constants and carriers for the multifunction terminal logic
package mtl_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int PULSE_MAX_HZ = 250;
	localparam int DEBOUNCE_US = 1000;
	localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
	localparam int DEB_W = 16;
	localparam int TICK_W = 23;
	localparam int VAL_W = 16;
	localparam int POS_W = 8;

	localparam logic [4:0] FN_COAST = 5'h11;
	localparam logic [4:0] FN_FAULT_RESET = 5'h12;
	localparam logic [4:0] FN_PID = 5'h13;
	localparam logic [4:0] FN_PLC = 5'h14;
	localparam logic [4:0] FN_TIMER1 = 5'h15;
	localparam logic [4:0] FN_TIMER2 = 5'h16;
	localparam logic [4:0] FN_COUNT = 5'h17;
	localparam logic [4:0] FN_COUNT_RST = 5'h18;
	localparam logic [4:0] FN_PLC_CLEAR = 5'h19;
	localparam logic [4:0] FN_WINDING = 5'h1A;

	localparam logic [5:0] OC_OFF = 6'h00;
	localparam logic [5:0] OC_RUNNING = 6'h01;
	localparam logic [5:0] OC_FREQ_REACHED = 6'h02;
	localparam logic [5:0] OC_FAULT = 6'h03;
	localparam logic [5:0] OC_ZERO_SPEED = 6'h04;
	localparam logic [5:0] OC_FREQ1 = 6'h05;
	localparam logic [5:0] OC_FREQ2 = 6'h06;
	localparam logic [5:0] OC_ACCEL = 6'h07;
	localparam logic [5:0] OC_DECEL = 6'h08;
	localparam logic [5:0] OC_UNDER_VOLT = 6'h09;
	localparam logic [5:0] OC_TIMER1 = 6'h0A;
	localparam logic [5:0] OC_TIMER2 = 6'h0B;
	localparam logic [5:0] OC_STAGE_DONE = 6'h0C;
	localparam logic [5:0] OC_PROG_DONE = 6'h0D;
	localparam logic [5:0] OC_PID_HIGH = 6'h0E;
	localparam logic [5:0] OC_PID_LOW = 6'h0F;
	localparam logic [5:0] OC_LOOP_OPEN = 6'h10;
	localparam logic [5:0] OC_OVERLOAD = 6'h11;
	localparam logic [5:0] OC_OVER_TORQUE = 6'h12;
	localparam logic [5:0] OC_WIND_DONE = 6'h1A;
	localparam logic [5:0] OC_COUNT_FINAL = 6'h1B;
	localparam logic [5:0] OC_COUNT_MID = 6'h1C;
	localparam logic [5:0] OC_MAX = 6'h20;
	localparam logic [5:0] OUT_A_DEFAULT = 6'h01;
	localparam logic [5:0] OUT_B_DEFAULT = 6'h02;
	localparam logic [5:0] RELAY_DEFAULT = 6'h03;

	localparam logic [2:0] MON_FREQ = 3'h0;
	localparam logic [2:0] MON_CURRENT = 3'h1;
	localparam logic [2:0] MON_DC = 3'h2;
	localparam logic [2:0] MON_AC = 3'h3;
	localparam logic [15:0] DC_SPAN_V = 16'h03E8;
	localparam logic [15:0] AC_SPAN_V = 16'h01FE;
	localparam logic [1:0] PID_MODE_TERMINAL = 2'h2;

	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_RUN = 2'b01,
		W_DONE = 2'b11
	} mtl_wind_t;

	typedef struct packed {
		logic running;
		logic freq_reached;
		logic fault;
		logic freq1_reached;
		logic freq2_reached;
		logic accel;
		logic decel;
		logic pid_high;
		logic pid_low;
		logic loop_open;
		logic overload;
		logic over_torque;
		logic winding_done;
		logic stage_done;
		logic program_done;
	} mtl_drive_t;

	typedef struct packed {
		logic [15:0] out_freq;
		logic [15:0] out_current;
		logic [15:0] dc_volt;
		logic [15:0] ac_volt;
	} mtl_meas_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic stable;
		logic rise;
		logic [DEB_W-1:0] cnt;
	} mtl_filt_t;
endpackage : mtl_pkg

// File: core/mtl_pulse_filter.sv
// synchroniser, debouncer and rising-edge detector for the count input
`timescale 1ns/1ps
module mtl_pulse_filter import mtl_pkg::*; #(
	parameter int DEB_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic raw,
	output logic rise
);
	mtl_filt_t s;
	mtl_filt_t next_s;

	always_comb begin
		next_s = s;
		next_s.sync1 = raw;
		next_s.sync2 = s.sync1;
		next_s.rise = 1'b0;
		// debounce must stay well under half the shortest legal pulse period
		if (s.sync2 == s.stable) begin
			next_s.cnt = '0;
		end else if (s.cnt >= DEB_W'(DEB_CYCLES - 1)) begin
			next_s.cnt = '0;
			next_s.stable = s.sync2;
			next_s.rise = s.sync2;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rise = s.rise;

	AST_ONE_PULSE: assert property (@(posedge clock)
		disable iff (!nrst) s.rise |=> !s.rise)
		else $error("count edge longer than one cycle");
endmodule : mtl_pulse_filter

// File: core/mtl_terminals.sv
// multifunction input decode, status output select and monitor select
`timescale 1ns/1ps
// Contract
// - coast-stop terminal removes drive output
// - fault-reset terminal acts as keypad reset
// - PID enable; mode 2 disables when open
// - PLC terminal closed starts PLC sequence
// - timer terminals start timers 1 and 2
// - pulse input counts; source keeps 250 Hz
// - counter reset terminal clears event count
// - PLC position retained; memory clear restarts
// - winding start; hold final frequency on completion
// - winding complete asserts, clears on stop
// - three outputs select 0-32, 0 inactive
// - code 1 running, code 3 fault
// - codes 2, 5, 6 frequency reached
// - code 4 below start-up frequency
// - code 7 accelerating, code 8 decelerating
// - code 9 under-voltage with alarm
// - codes 10, 11 timer reached, clear on release
// - codes 12, 13 stage and program pulses
// - codes 14, 15 PID upper and lower
// - code 16 loop open alarm; 17, 18
// - codes 27 final, 28 intermediate count
// - monitors select frequency, current, DC, AC
// - final count reached restarts count at zero
module mtl_terminals import mtl_pkg::*; #(
	parameter int N_TERM = 6,
	parameter int TICK = TICK_CYCLES,
	parameter int DEB_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [N_TERM-1:0] term_in,
	input wire logic [N_TERM-1:0][4:0] term_func,
	input wire mtl_drive_t drive,
	input wire mtl_meas_t meas,
	input wire logic [15:0] start_freq,
	input wire logic [15:0] uv_threshold,
	input wire logic [1:0] pid_mode_setting,
	input wire logic [15:0] timer1_set,
	input wire logic [15:0] timer2_set,
	input wire logic [15:0] final_count_setting,
	input wire logic [15:0] intermediate_count_setting,
	input wire logic [5:0] digital_output_a_select,
	input wire logic [5:0] digital_output_b_select,
	input wire logic [5:0] relay_output_select,
	input wire logic [2:0] voltage_monitor_select,
	input wire logic [2:0] current_monitor_select,
	output logic coast_stop,
	output logic fault_reset,
	output logic pid_enable,
	output logic plc_run,
	output logic [POS_W-1:0] plc_position,
	output logic winding_run,
	output logic winding_hold,
	output logic uv_alarm,
	output logic loop_alarm,
	output logic [VAL_W-1:0] event_count,
	output logic digital_output_a,
	output logic second_digital_output,
	output logic relay_contact_set,
	output logic [15:0] voltage_monitor_output,
	output logic [15:0] current_monitor_output
);
	typedef struct packed {
		logic coast;
		logic freset;
		logic pid;
		logic plc;
		logic [POS_W-1:0] pos;
		logic stage_pulse;
		logic prog_pulse;
		mtl_wind_t wind;
		logic wind_run;
		logic wind_done;
		logic uv;
		logic loop;
		logic [TICK_W-1:0] div;
		logic [VAL_W-1:0] t1;
		logic [VAL_W-1:0] t2;
		logic t1_hit;
		logic t2_hit;
		logic [VAL_W-1:0] cnt;
		logic cnt_hit;
		logic mid_hit;
		logic out_a;
		logic out_b;
		logic out_r;
		logic [15:0] mon_v;
		logic [15:0] mon_c;
	} mtl_core_t;

	mtl_core_t s;
	mtl_core_t next_s;
	logic [26:17] fn;
	logic count_edge;
	logic tick;
	logic [32:0] vec;

	function automatic logic fn_on(input logic [N_TERM-1:0] lvl,
		input logic [N_TERM-1:0][4:0] cfg, input logic [4:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_TERM; i++) begin
			hit = hit | (lvl[i] & (cfg[i] == code));
		end
		return hit;
	endfunction : fn_on

	// out-of-range codes fall back to the terminal's default
	function automatic logic pick(input logic [5:0] sel,
		input logic [5:0] dflt, input logic [32:0] v);
		logic [5:0] code;
		code = (sel > OC_MAX) ? dflt : sel;
		return (code == OC_OFF) ? 1'b0 : v[code];
	endfunction : pick

	function automatic logic [15:0] mon_val(input logic [2:0] sel,
		input mtl_meas_t m);
		logic [15:0] v;
		v = 16'h0000;
		case (sel)
			MON_FREQ: v = m.out_freq;
			MON_CURRENT: v = m.out_current;
			MON_DC: v = (m.dc_volt > DC_SPAN_V) ? DC_SPAN_V : m.dc_volt;
			MON_AC: v = (m.ac_volt > AC_SPAN_V) ? AC_SPAN_V : m.ac_volt;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : mon_val

	always_comb begin
		for (int c = 17; c <= 26; c++) begin
			fn[c] = fn_on(term_in, term_func, 5'(c));
		end
	end

	mtl_pulse_filter #(
		.DEB_CYCLES(DEB_CYCLES)
	) u_count_filter (
		.clock(clock),
		.nrst(nrst),
		.raw(fn[FN_COUNT]),
		.rise(count_edge)
	);

	assign tick = (s.div == TICK_W'(TICK - 1));

	always_comb begin
		vec = '0;
		vec[OC_RUNNING] = drive.running;
		vec[OC_FREQ_REACHED] = drive.freq_reached;
		vec[OC_FAULT] = drive.fault;
		vec[OC_ZERO_SPEED] = meas.out_freq < start_freq;
		vec[OC_FREQ1] = drive.freq1_reached;
		vec[OC_FREQ2] = drive.freq2_reached;
		vec[OC_ACCEL] = drive.accel;
		vec[OC_DECEL] = drive.decel;
		vec[OC_UNDER_VOLT] = s.uv;
		vec[OC_TIMER1] = s.t1_hit;
		vec[OC_TIMER2] = s.t2_hit;
		vec[OC_STAGE_DONE] = s.stage_pulse;
		vec[OC_PROG_DONE] = s.prog_pulse;
		vec[OC_PID_HIGH] = drive.pid_high;
		vec[OC_PID_LOW] = drive.pid_low;
		vec[OC_LOOP_OPEN] = s.loop;
		vec[OC_OVERLOAD] = drive.overload;
		vec[OC_OVER_TORQUE] = drive.over_torque;
		vec[OC_WIND_DONE] = s.wind_done;
		vec[OC_COUNT_FINAL] = s.cnt_hit;
		vec[OC_COUNT_MID] = s.mid_hit;
	end

	always_comb begin
		next_s = s;
		next_s.coast = fn[FN_COAST];
		next_s.freset = fn[FN_FAULT_RESET];
		// terminal mode follows the contact; mode 0 turns PID off, modes 1 and 3 leave it on
		if (pid_mode_setting == PID_MODE_TERMINAL) begin
			next_s.pid = fn[FN_PID];
		end else begin
			next_s.pid = pid_mode_setting != 2'h0;
		end
		next_s.plc = fn[FN_PLC];
		next_s.stage_pulse = s.plc & drive.stage_done;
		next_s.prog_pulse = s.plc & drive.program_done;
		// position survives fault and stop; only clear or finish resets it
		if (fn[FN_PLC_CLEAR] || (s.plc && drive.program_done)) begin
			next_s.pos = '0;
		end else if (s.plc && drive.stage_done) begin
			next_s.pos = s.pos + 1'b1;
		end
		next_s.uv = meas.dc_volt < uv_threshold;
		next_s.loop = drive.loop_open;
		next_s.div = tick ? '0 : s.div + 1'b1;

		// timers run in ticks; releasing the start input clears all
		if (!fn[FN_TIMER1]) begin
			next_s.t1 = '0;
			next_s.t1_hit = 1'b0;
		end else begin
			next_s.t1_hit = s.t1 >= timer1_set;
			if (tick && !next_s.t1_hit) begin
				next_s.t1 = s.t1 + 1'b1;
			end
		end
		if (!fn[FN_TIMER2]) begin
			next_s.t2 = '0;
			next_s.t2_hit = 1'b0;
		end else begin
			next_s.t2_hit = s.t2 >= timer2_set;
			if (tick && !next_s.t2_hit) begin
				next_s.t2 = s.t2 + 1'b1;
			end
		end

		// a fresh final-count edge wins over a same-cycle reset
		if (fn[FN_COUNT_RST]) begin
			next_s.cnt = '0;
			next_s.cnt_hit = 1'b0;
		end else if (count_edge) begin
			next_s.cnt_hit = 1'b0;
			if (s.cnt + 1'b1 >= final_count_setting) begin
				next_s.cnt = '0;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
		if (count_edge && (s.cnt + 1'b1 >= final_count_setting)) begin
			next_s.cnt_hit = 1'b1;
		end
		next_s.mid_hit = (next_s.cnt >= intermediate_count_setting) &&
			(intermediate_count_setting != 16'h0000);

		next_s.wind_run = 1'b0;
		next_s.wind_done = 1'b0;
		case (s.wind)
			W_IDLE: begin
				if (fn[FN_WINDING] && drive.running) begin
					next_s.wind = W_RUN;
					next_s.wind_run = 1'b1;
				end
			end
			W_RUN: begin
				if (drive.winding_done) begin
					next_s.wind = W_DONE;
					next_s.wind_done = 1'b1;
				end else if (!drive.running) begin
					next_s.wind = W_IDLE;
				end else begin
					next_s.wind_run = 1'b1;
				end
			end
			W_DONE: begin
				if (!drive.running && !drive.winding_done) begin
					next_s.wind = W_IDLE;
				end else begin
					next_s.wind_done = 1'b1;
				end
			end
			default: next_s.wind = W_IDLE;
		endcase

		next_s.out_a = pick(digital_output_a_select, OUT_A_DEFAULT, vec);
		next_s.out_b = pick(digital_output_b_select, OUT_B_DEFAULT, vec);
		next_s.out_r = pick(relay_output_select, RELAY_DEFAULT, vec);
		next_s.mon_v = mon_val(voltage_monitor_select, meas);
		next_s.mon_c = mon_val(current_monitor_select, meas);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign coast_stop = s.coast;
	assign fault_reset = s.freset;
	assign pid_enable = s.pid;
	assign plc_run = s.plc;
	assign plc_position = s.pos;
	assign winding_run = s.wind_run;
	assign winding_hold = s.wind_done;
	assign uv_alarm = s.uv;
	assign loop_alarm = s.loop;
	assign event_count = s.cnt;
	assign digital_output_a = s.out_a;
	assign second_digital_output = s.out_b;
	assign relay_contact_set = s.out_r;
	assign voltage_monitor_output = s.mon_v;
	assign current_monitor_output = s.mon_c;

	sequence s_wind_go;
		s.wind == W_IDLE && fn[FN_WINDING] && drive.running;
	endsequence
	sequence s_wind_finish;
		s.wind == W_RUN && drive.winding_done;
	endsequence
	sequence s_count_wrap;
		count_edge && !fn[FN_COUNT_RST] &&
			(s.cnt + 1'b1 >= final_count_setting);
	endsequence

	AST_COAST: assert property (@(posedge clock) disable iff (!nrst)
		fn[FN_COAST] |=> coast_stop) else $error("coast stop missed");
	AST_FRESET: assert property (@(posedge clock) disable iff (!nrst)
		$rose(fn[FN_FAULT_RESET]) |=> $rose(fault_reset))
		else $error("fault reset missed");
	AST_PID_OFF: assert property (@(posedge clock) disable iff (!nrst)
		pid_mode_setting == PID_MODE_TERMINAL && !fn[FN_PID] |=> !pid_enable)
		else $error("pid on with contact open");
	AST_PLC: assert property (@(posedge clock) disable iff (!nrst)
		fn[FN_PLC] |=> plc_run) else $error("plc not started");
	AST_T1_CLR: assert property (@(posedge clock) disable iff (!nrst)
		!fn[FN_TIMER1] |=> !s.t1_hit) else $error("timer1 flag stuck");
	AST_CNT_RST: assert property (@(posedge clock) disable iff (!nrst)
		fn[FN_COUNT_RST] |=> event_count == 16'h0000)
		else $error("counter not cleared");
	AST_CNT_WRAP: assert property (@(posedge clock) disable iff (!nrst)
		s_count_wrap |=> event_count == 16'h0000 && s.cnt_hit)
		else $error("final count wrap wrong");
	AST_CNT_STEP: assert property (@(posedge clock) disable iff (!nrst)
		!count_edge && !fn[FN_COUNT_RST] |=> $stable(event_count))
		else $error("count moved without edge");
	AST_MEM_CLR: assert property (@(posedge clock) disable iff (!nrst)
		fn[FN_PLC_CLEAR] |=> plc_position == 8'h00)
		else $error("plc position kept");
	AST_WIND: assert property (@(posedge clock) disable iff (!nrst)
		s_wind_go ##1 s_wind_finish |=> winding_hold && !winding_run)
		else $error("winding completion missed");
	AST_WIND_CLR: assert property (@(posedge clock) disable iff (!nrst)
		s.wind == W_DONE && !drive.running && !drive.winding_done
		|=> !winding_hold [*2]) else $error("winding flag not cleared");
	AST_OUT_OFF: assert property (@(posedge clock) disable iff (!nrst)
		digital_output_a_select == OC_OFF |=> !digital_output_a)
		else $error("code 0 output active");
	AST_UV: assert property (@(posedge clock) disable iff (!nrst)
		meas.dc_volt < uv_threshold |=> uv_alarm ##1
		($past(relay_output_select) != OC_UNDER_VOLT || relay_contact_set))
		else $error("under-voltage not flagged");
	AST_DC_SPAN: assert property (@(posedge clock) disable iff (!nrst)
		voltage_monitor_select == MON_DC |=> voltage_monitor_output <= DC_SPAN_V)
		else $error("dc monitor over span");
endmodule : mtl_terminals

// File: verification/mtl_contact_model.sv
// switch contact model driving the count input with clean pulses
`timescale 1ns/1ps
module mtl_contact_model #(
	parameter int HOLD = 12
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic fire,
	output logic contact,
	output logic busy
);
	int cnt;
	// one closure per request, high then low for HOLD cycles each
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end else if (fire) begin
			cnt <= 2 * HOLD;
		end
	end
	// open contact reads 0; rate stays far below the filter limit
	assign contact = cnt > HOLD;
	assign busy = cnt != 0;
endmodule : mtl_contact_model

// File: verification/multifunction_terminal_logic_tb_top.sv
// random and directed bench for the multifunction terminal logic
`timescale 1ns/1ps
module multifunction_terminal_logic_tb_top;
	import mtl_pkg::*;
	localparam int TK = 8;
	logic clock = 0, nrst = 0, fire = 0, contact, busy;
	logic [5:0] sw = 0;
	wire logic [5:0] term_in = {sw[5], contact, sw[3:0]};
	logic [5:0][4:0] term_func;
	mtl_drive_t drive = '0;
	mtl_meas_t meas = '0;
	logic [15:0] start_freq = 0, uv_threshold = 0, t1 = 0, t2 = 0;
	logic [15:0] fin = 16'h0003, mid = 16'h0002;
	logic [1:0] pid_mode_setting = 0;
	logic [5:0] sel_a = 6'h3F, sel_b = 6'h3F, sel_r = 6'h3F;
	logic [2:0] vsel = 0, csel = 0;
	logic coast_stop, fault_reset, pid_enable, plc_run, winding_run;
	logic winding_hold, uv_alarm, loop_alarm, digital_output_a;
	logic second_digital_output, relay_contact_set;
	logic [7:0] plc_position;
	logic [15:0] event_count, vmon, cmon;
	int mismatches = 0, comparisons = 0, i, k;

	initial forever #12.5 clock = ~clock;

	mtl_contact_model #(.HOLD(12)) mtl_contact_model_i (.clock, .nrst,
		.fire, .contact, .busy);

	mtl_terminals #(.N_TERM(6), .TICK(TK), .DEB_CYCLES(4)) mtl_terminals_i (
		.clock, .nrst, .term_in, .term_func, .drive, .meas, .start_freq,
		.uv_threshold, .pid_mode_setting, .timer1_set(t1), .timer2_set(t2),
		.final_count_setting(fin), .intermediate_count_setting(mid),
		.digital_output_a_select(sel_a), .digital_output_b_select(sel_b),
		.relay_output_select(sel_r), .voltage_monitor_select(vsel),
		.current_monitor_select(csel), .coast_stop, .fault_reset,
		.pid_enable, .plc_run, .plc_position, .winding_run, .winding_hold,
		.uv_alarm, .loop_alarm, .event_count, .digital_output_a,
		.second_digital_output, .relay_contact_set,
		.voltage_monitor_output(vmon), .current_monitor_output(cmon));

	task automatic chk1(string n, logic e, logic g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0b seen %0b", n, e, g);
		end
	endtask : chk1

	task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk16

	task automatic cyc(int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	task automatic finish_test;
		if (mismatches == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	task automatic give_up(int n, int lim);
		if (n >= lim) begin
			mismatches++;
			finish_test;
		end
	endtask : give_up

	// bounded wait keeps a stuck contact model from hanging the run
	task automatic pulse;
		fire = 1;
		cyc(1);
		fire = 0;
		for (k = 0; k < 100 && busy !== 1'b0; k++) cyc(1);
		give_up(k, 100);
		cyc(3);
	endtask : pulse

	// stateful codes left out of random picks; they get directed tests
	function automatic logic [5:0] rsel();
		logic [5:0] s;
		s = 6'($urandom);
		if (s inside {6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h1A, 6'h1B, 6'h1C})
			s = OC_OFF;
		return s;
	endfunction : rsel

	function automatic logic exp_pick(logic [5:0] s, logic [5:0] dflt);
		case ((s > OC_MAX) ? dflt : s)
			OC_RUNNING: return drive.running;
			OC_FREQ_REACHED: return drive.freq_reached;
			OC_FAULT: return drive.fault;
			OC_ZERO_SPEED: return meas.out_freq < start_freq;
			OC_FREQ1: return drive.freq1_reached;
			OC_FREQ2: return drive.freq2_reached;
			OC_ACCEL: return drive.accel;
			OC_DECEL: return drive.decel;
			OC_UNDER_VOLT: return meas.dc_volt < uv_threshold;
			OC_PID_HIGH: return drive.pid_high;
			OC_PID_LOW: return drive.pid_low;
			OC_LOOP_OPEN: return drive.loop_open;
			OC_OVERLOAD: return drive.overload;
			OC_OVER_TORQUE: return drive.over_torque;
			default: return 1'b0;
		endcase
	endfunction : exp_pick

	function automatic logic [15:0] exp_mon(logic [2:0] s);
		case (s)
			MON_FREQ: return meas.out_freq;
			MON_CURRENT: return meas.out_current;
			MON_DC: return meas.dc_volt > DC_SPAN_V ? DC_SPAN_V : meas.dc_volt;
			MON_AC: return meas.ac_volt > AC_SPAN_V ? AC_SPAN_V : meas.ac_volt;
			default: return 16'h0000;
		endcase
	endfunction : exp_mon

	initial begin
		term_func = {FN_COUNT_RST, FN_COUNT, FN_TIMER1, FN_PID,
			FN_FAULT_RESET, FN_COAST};
		void'($urandom(32'h0add2613));
		repeat (8) @(posedge clock);
		@(negedge clock);
		nrst = 1;
		for (i = 0; i < 40; i++) begin
			sw[2:0] = 3'($urandom);
			pid_mode_setting = 2'($urandom);
			term_func[0] = ($urandom % 2) ? FN_COAST : 5'h05;
			cyc(1);
			chk1("coast", sw[0] && term_func[0] == FN_COAST, coast_stop);
			chk1("fault_reset", sw[1], fault_reset);
			chk1("pid", (pid_mode_setting == PID_MODE_TERMINAL) ? sw[2] :
				pid_mode_setting != 2'h0, pid_enable);
		end
		sw = 0;
		term_func[0] = FN_COAST;
		for (i = 0; i < 60; i++) begin
			drive = mtl_drive_t'(15'($urandom));
			{drive.stage_done, drive.program_done, drive.winding_done} = 3'h0;
			meas = {16'($urandom), 16'($urandom),
				16'($urandom_range(0, 2000)), 16'($urandom_range(0, 1000))};
			start_freq = 16'($urandom);
			uv_threshold = 16'($urandom_range(0, 2000));
			if (i > 0) {sel_a, sel_b, sel_r} = {rsel(), rsel(), rsel()};
			{vsel, csel} = 6'($urandom);
			cyc(3);
			chk1("out_a", exp_pick(sel_a, OUT_A_DEFAULT),
				digital_output_a);
			chk1("out_b", exp_pick(sel_b, OUT_B_DEFAULT),
				second_digital_output);
			chk1("relay", exp_pick(sel_r, RELAY_DEFAULT),
				relay_contact_set);
			chk1("uv", meas.dc_volt < uv_threshold, uv_alarm);
			chk1("loop", drive.loop_open, loop_alarm);
			chk16("vmon", exp_mon(vsel), vmon);
			chk16("cmon", exp_mon(csel), cmon);
		end
		drive = '0;
		{sel_a, sel_b, sel_r} = {OC_TIMER1, OC_TIMER2, OC_COUNT_FINAL};
		{t1, t2} = {16'h0003, 16'hFFFF};
		term_func[2] = FN_TIMER2;
		sw[3:2] = 2'h3;
		cyc(2 * TK);
		chk1("timer1_early", 1'b0, digital_output_a);
		for (k = 0; k < 40 && digital_output_a !== 1'b1; k++) cyc(1);
		give_up(k, 40);
		chk1("timer2_idle", 1'b0, second_digital_output);
		sw[3] = 0;
		t2 = 16'h0000;
		cyc(3);
		chk1("timer1_clear", 1'b0, digital_output_a);
		chk1("timer2_hit", 1'b1, second_digital_output);
		sw[2] = 0;
		cyc(3);
		chk1("timer2_clear", 1'b0, second_digital_output);
		sel_b = OC_COUNT_MID;
		for (i = 1; i <= 4; i++) begin
			pulse();
			chk16("count", 16'(i % 3), event_count);
			chk1("count_final", i == 3, relay_contact_set);
			chk1("count_mid", (i % 3) >= 2, second_digital_output);
		end
		sw[5] = 1;
		cyc(2);
		sw[5] = 0;
		chk16("count_reset", 16'h0000, event_count);
		pulse();
		chk16("count_again", 16'h0001, event_count);
		term_func[0] = FN_WINDING;
		sel_a = OC_WIND_DONE;
		drive.running = 1;
		sw[0] = 1;
		cyc(1);
		chk1("wind_run", 1'b1, winding_run);
		chk1("wind_out_early", 1'b0, digital_output_a);
		drive.winding_done = 1;
		cyc(3);
		chk1("wind_hold", 1'b1, winding_hold);
		chk1("wind_out", 1'b1, digital_output_a);
		{sw[0], drive.winding_done} = 2'h0;
		cyc(3);
		chk1("wind_keep", 1'b1, winding_hold);
		drive.running = 0;
		cyc(3);
		chk1("wind_stop", 1'b0, digital_output_a);
		term_func[1] = FN_PLC;
		term_func[2] = FN_PLC_CLEAR;
		sel_b = OC_STAGE_DONE;
		sw[1] = 1;
		cyc(2);
		chk1("plc_run", 1'b1, plc_run);
		for (i = 1; i <= 3; i++) begin
			drive.stage_done = 1;
			cyc(1);
			drive.stage_done = 0;
			cyc(1);
			chk1("stage_pulse", 1'b1, second_digital_output);
			cyc(1);
			chk1("stage_end", 1'b0, second_digital_output);
			chk16("plc_pos", 16'(i), {8'h00, plc_position});
		end
		sw[1] = 0;
		cyc(3);
		chk16("plc_keep", 16'h0003, {8'h00, plc_position});
		sw[2] = 1;
		cyc(3);
		chk16("plc_clear", 16'h0000, {8'h00, plc_position});
		// program finish: pulse on code 13 and position back to zero
		sw[2:1] = 2'h1;
		sel_b = OC_PROG_DONE;
		cyc(2);
		drive.stage_done = 1;
		cyc(1);
		chk16("plc_step", 16'h0001, {8'h00, plc_position});
		drive.stage_done = 0;
		drive.program_done = 1;
		cyc(1);
		drive.program_done = 0;
		cyc(1);
		chk1("prog_pulse", 1'b1, second_digital_output);
		cyc(1);
		chk1("prog_end", 1'b0, second_digital_output);
		chk16("plc_done", 16'h0000, {8'h00, plc_position});
		finish_test;
	end

	// hard stop should a wait ever slip past its bound
	initial begin
		repeat (50000) @(posedge clock);
		mismatches++;
		finish_test;
	end
endmodule : multifunction_terminal_logic_tb_top
